// file: rtl/djtp_pkg.sv
// constants and types of the debug, test access and trace port
package djtp_pkg;

  // test access port
  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0ABC_D001;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAUSE_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } djtp_tap_t;

  // debug serial link
  localparam int PKT_W = 17;
  localparam logic [4:0] PKT_LAST = 5'h10;
  localparam logic [7:0] CMD_WRITE_CFG = 8'hC8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_BKD_BIT = 0;
  localparam int CFG_PCD_BIT = 1;

  // processor status values
  localparam logic [3:0] PST_HALT = 4'hF;
  localparam logic [3:0] PST_START_C = 4'hC;
  localparam logic [3:0] PST_START_D = 4'hD;
  localparam logic [3:0] PST_RESET = 4'h0;

  typedef struct packed {
    logic [3:0] status;
    logic [3:0] data;
  } djtp_trace_t;

endpackage

// file: rtl/djtp_top.sv
// debug port: test access port, debug serial link, breakpoint and trace outputs
// Function
// - jtag_select level caught at reset picks debug module or test access port.
// - active-low test reset initialises test access logic asynchronously.
// - tms sampled on rising test clock steps the state machine.
// - tdi sampled on rising test clock edge.
// - tdo driven only in shift-IR and shift-DR, otherwise tri-stated.
// - tdo changes only on falling test clock edge.
// - serial clock level accepted after equal value on two bus clock edges.
// - on synchronised serial clock rise, sample serial input, update serial output.
// - serial output comes from a register, one bus clock after clock validated high.
// - breakpoint request halts after current instruction, status shows 0xF.
// - with breakpoint-disable bit set, breakpoint raises debug interrupt instead.
// - status clock toggles every bus clock (half its rate), rising mid valid status and data.
// - status-clock-disable freezes status clock, status and data; triggers stay.
// - after reset status clock idles until status 0xC, 0xD or 0xF.
// - all_status_and is AND of the four status bits.
// - status bits driven synchronously with processor clock.
// - captured trace data appears on four-bit debug data; breakpoint status 0xF shows on proc_status.
`timescale 1ns/100ps
module djtp_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic jtag_select,
  input wire logic trst_n,
  input wire logic tclk,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic dev_serial_clock,
  input wire logic dev_serial_in,
  output logic dev_serial_out,
  input wire logic breakpoint_request,
  input wire djtp_pkg::djtp_trace_t core_trace,
  input wire logic instr_done,
  input wire logic resume,
  output logic halt_request,
  output logic debug_irq,
  output logic jtag_mode,
  output logic [3:0] proc_status,
  output logic [3:0] debug_data,
  output logic status_clock,
  output logic all_status_and
);

  // pin synchronisers
  logic jsel_s1, jsel_s2;
  logic sclk_s1, sclk_s2, sclk_s3;
  logic sin_s1, sin_s2;
  logic breakpoint_request_s1, breakpoint_request_s2, breakpoint_request_d;

  always_ff @(posedge clk) begin
    jsel_s1 <= jtag_select;
    jsel_s2 <= jsel_s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sin_s1 <= 1'b0;
      sin_s2 <= 1'b0;
      breakpoint_request_s1 <= 1'b0;
      breakpoint_request_s2 <= 1'b0;
      breakpoint_request_d <= 1'b0;
    end else begin
      sclk_s1 <= dev_serial_clock;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sin_s1 <= dev_serial_in;
      sin_s2 <= sin_s1;
      breakpoint_request_s1 <= breakpoint_request;
      breakpoint_request_s2 <= breakpoint_request_s1;
      breakpoint_request_d <= breakpoint_request_s2;
    end
  end

  // mode strap
  always_ff @(posedge clk) begin
    if (reset) begin
      jtag_mode <= jsel_s2;
    end
  end

  // serial clock validation
  logic sclk_valid_reg, sclk_valid_d;
  logic ser_rise;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_valid_reg <= 1'b0;
      sclk_valid_d <= 1'b0;
    end else begin
      if (sclk_s2 == sclk_s3) begin
        sclk_valid_reg <= sclk_s3;
      end
      sclk_valid_d <= sclk_valid_reg;
    end
  end

  assign ser_rise = sclk_valid_reg & ~sclk_valid_d & ~jtag_mode;

  // serial packet engine and configuration
  logic [djtp_pkg::PKT_W-1:0] rx_shift, tx_shift, rx_full;
  logic [4:0] bit_cnt;
  logic [7:0] cfg_reg;

  assign rx_full = {rx_shift[djtp_pkg::PKT_W-2:0], sin_s2};

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_shift <= '0;
      tx_shift <= '0;
      bit_cnt <= '0;
      cfg_reg <= djtp_pkg::CFG_RESET;
      dev_serial_out <= 1'b0;
    end else if (ser_rise) begin
      rx_shift <= rx_full;
      dev_serial_out <= tx_shift[djtp_pkg::PKT_W-1];
      if (bit_cnt == djtp_pkg::PKT_LAST) begin
        bit_cnt <= '0;
        tx_shift <= {9'h000, cfg_reg};
        if (rx_full[15:8] == djtp_pkg::CMD_WRITE_CFG) begin
          cfg_reg <= rx_full[7:0];
        end
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
        tx_shift <= {tx_shift[djtp_pkg::PKT_W-2:0], 1'b0};
      end
    end
  end

  // breakpoint handling
  logic breakpoint_disable_bit, status_clock_disable_bit, breakpoint_request_rise, halt_pend;

  assign breakpoint_disable_bit = cfg_reg[djtp_pkg::CFG_BKD_BIT];
  assign status_clock_disable_bit = cfg_reg[djtp_pkg::CFG_PCD_BIT];
  assign breakpoint_request_rise = breakpoint_request_s2 & ~breakpoint_request_d;

  always_ff @(posedge clk) begin
    if (reset) begin
      halt_pend <= 1'b0;
      halt_request <= 1'b0;
      debug_irq <= 1'b0;
    end else begin
      debug_irq <= breakpoint_request_rise & breakpoint_disable_bit;
      if (instr_done && (halt_pend || (breakpoint_request_rise && !breakpoint_disable_bit))) begin
        halt_request <= 1'b1;
        halt_pend <= 1'b0;
      end else if (breakpoint_request_rise && !breakpoint_disable_bit) begin
        halt_pend <= 1'b1;
      end else if (resume) begin
        halt_request <= 1'b0;
      end
    end
  end

  // trace outputs
  logic started_reg;
  logic [3:0] status_next;

  always_comb begin
    status_next = halt_request ? djtp_pkg::PST_HALT : core_trace.status;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      started_reg <= 1'b0;
    end else if (core_trace.status == djtp_pkg::PST_START_C || core_trace.status == djtp_pkg::PST_START_D
                 || core_trace.status == djtp_pkg::PST_HALT) begin
      started_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status_clock <= 1'b0;
      proc_status <= djtp_pkg::PST_RESET;
      debug_data <= 4'h0;
      all_status_and <= 1'b0;
    end else if (started_reg && !status_clock_disable_bit) begin
      status_clock <= ~status_clock;
      if (status_clock) begin
        proc_status <= status_next;
        debug_data <= core_trace.data;
        all_status_and <= &status_next;
      end
    end
  end

  // test access port, test clock domain
  logic jm_s1, jm_s2;
  djtp_pkg::djtp_tap_t tap_state, tap_next;
  logic [3:0] ir_reg, ir_shift;
  logic [31:0] dr_shift;
  logic bypass_reg, tdo_rise_reg;

  always_ff @(posedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      jm_s1 <= 1'b0;
      jm_s2 <= 1'b0;
    end else begin
      jm_s1 <= jtag_mode;
      jm_s2 <= jm_s1;
    end
  end

  always_comb begin
    case (tap_state)
      djtp_pkg::TAP_RESET: tap_next = tms ? djtp_pkg::TAP_RESET : djtp_pkg::TAP_IDLE;
      djtp_pkg::TAP_IDLE: tap_next = tms ? djtp_pkg::TAP_SEL_DR : djtp_pkg::TAP_IDLE;
      djtp_pkg::TAP_SEL_DR: tap_next = tms ? djtp_pkg::TAP_SEL_IR : djtp_pkg::TAP_CAP_DR;
      djtp_pkg::TAP_CAP_DR: tap_next = tms ? djtp_pkg::TAP_EX1_DR : djtp_pkg::TAP_SH_DR;
      djtp_pkg::TAP_SH_DR: tap_next = tms ? djtp_pkg::TAP_EX1_DR : djtp_pkg::TAP_SH_DR;
      djtp_pkg::TAP_EX1_DR: tap_next = tms ? djtp_pkg::TAP_UPD_DR : djtp_pkg::TAP_PAUSE_DR;
      djtp_pkg::TAP_PAUSE_DR: tap_next = tms ? djtp_pkg::TAP_EX2_DR : djtp_pkg::TAP_PAUSE_DR;
      djtp_pkg::TAP_EX2_DR: tap_next = tms ? djtp_pkg::TAP_UPD_DR : djtp_pkg::TAP_SH_DR;
      djtp_pkg::TAP_UPD_DR: tap_next = tms ? djtp_pkg::TAP_SEL_DR : djtp_pkg::TAP_IDLE;
      djtp_pkg::TAP_SEL_IR: tap_next = tms ? djtp_pkg::TAP_RESET : djtp_pkg::TAP_CAP_IR;
      djtp_pkg::TAP_CAP_IR: tap_next = tms ? djtp_pkg::TAP_EX1_IR : djtp_pkg::TAP_SH_IR;
      djtp_pkg::TAP_SH_IR: tap_next = tms ? djtp_pkg::TAP_EX1_IR : djtp_pkg::TAP_SH_IR;
      djtp_pkg::TAP_EX1_IR: tap_next = tms ? djtp_pkg::TAP_UPD_IR : djtp_pkg::TAP_PAUSE_IR;
      djtp_pkg::TAP_PAUSE_IR: tap_next = tms ? djtp_pkg::TAP_EX2_IR : djtp_pkg::TAP_PAUSE_IR;
      djtp_pkg::TAP_EX2_IR: tap_next = tms ? djtp_pkg::TAP_UPD_IR : djtp_pkg::TAP_SH_IR;
      djtp_pkg::TAP_UPD_IR: tap_next = tms ? djtp_pkg::TAP_SEL_DR : djtp_pkg::TAP_IDLE;
      default: tap_next = djtp_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      tap_state <= djtp_pkg::TAP_RESET;
    end else if (!jm_s2) begin
      tap_state <= djtp_pkg::TAP_RESET;
    end else begin
      tap_state <= tap_next;
    end
  end

  always_ff @(posedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      ir_reg <= djtp_pkg::IR_IDCODE;
      ir_shift <= '0;
      dr_shift <= '0;
      bypass_reg <= 1'b0;
      tdo_rise_reg <= 1'b0;
    end else begin
      tdo_rise_reg <= tdo;
      case (tap_state)
        djtp_pkg::TAP_RESET: ir_reg <= djtp_pkg::IR_IDCODE;
        djtp_pkg::TAP_CAP_IR: ir_shift <= djtp_pkg::IR_CAPTURE;
        djtp_pkg::TAP_SH_IR: ir_shift <= {tdi, ir_shift[3:1]};
        djtp_pkg::TAP_UPD_IR: ir_reg <= ir_shift;
        djtp_pkg::TAP_CAP_DR: begin
          dr_shift <= djtp_pkg::ID_VALUE;
          bypass_reg <= 1'b0;
        end
        djtp_pkg::TAP_SH_DR: begin
          dr_shift <= {tdi, dr_shift[31:1]};
          bypass_reg <= tdi;
        end
        default: ;
      endcase
    end
  end

  always_ff @(negedge tclk or negedge trst_n) begin
    if (!trst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_oe <= tap_state == djtp_pkg::TAP_SH_IR || tap_state == djtp_pkg::TAP_SH_DR;
      if (tap_state == djtp_pkg::TAP_SH_IR) begin
        tdo <= ir_shift[0];
      end else if (ir_reg == djtp_pkg::IR_BYPASS) begin
        tdo <= bypass_reg;
      end else begin
        tdo <= dr_shift[0];
      end
    end
  end

  // checks, bus clock domain
  sequence s_sclk_stable_high;
    sclk_s2 && sclk_s3;
  endsequence

  property p_sclk_valid;
    @(posedge clk) disable iff (reset)
      $rose(sclk_valid_reg) |-> $past(sclk_s2) && $past(sclk_s3);
  endproperty
  a_sclk_valid: assert property (p_sclk_valid) else $error("serial clock accepted unvalidated");
  property p_sclk_accept;
    @(posedge clk) disable iff (reset)
      s_sclk_stable_high |=> sclk_valid_reg;
  endproperty
  a_sclk_accept: assert property (p_sclk_accept) else $error("stable serial clock not accepted");
  property p_dso_update;
    @(posedge clk) disable iff (reset)
      ser_rise |=> dev_serial_out == $past(tx_shift[djtp_pkg::PKT_W-1]);
  endproperty
  a_dso_update: assert property (p_dso_update) else $error("serial output not updated");
  property p_dso_hold;
    @(posedge clk) disable iff (reset)
      !ser_rise |=> $stable(dev_serial_out);
  endproperty
  a_dso_hold: assert property (p_dso_hold) else $error("serial output moved off edge");
  sequence s_breakpoint_request_halt_req;
    breakpoint_request_rise && !breakpoint_disable_bit && instr_done;
  endsequence
  property p_halt;
    @(posedge clk) disable iff (reset)
      s_breakpoint_request_halt_req |=> halt_request;
  endproperty
  a_halt: assert property (p_halt) else $error("breakpoint did not halt");
  property p_bkd_irq;
    @(posedge clk) disable iff (reset)
      breakpoint_request_rise && breakpoint_disable_bit && !halt_pend && !halt_request |=> debug_irq && !halt_request;
  endproperty
  a_bkd_irq: assert property (p_bkd_irq) else $error("disabled breakpoint not an interrupt");
  property p_halt_status;
    @(posedge clk) disable iff (reset)
      halt_request && started_reg && !status_clock_disable_bit && status_clock |=> proc_status == djtp_pkg::PST_HALT;
  endproperty
  a_halt_status: assert property (p_halt_status) else $error("halt status not 0xF");
  property p_pcd_freeze;
    @(posedge clk) disable iff (reset)
      status_clock_disable_bit |=> $stable(status_clock) && $stable(proc_status) && $stable(debug_data);
  endproperty
  a_pcd_freeze: assert property (p_pcd_freeze) else $error("trace moved while disabled");
  property p_idle_until_start;
    @(posedge clk) disable iff (reset)
      !started_reg |=> !status_clock && proc_status == djtp_pkg::PST_RESET;
  endproperty
  a_idle_until_start: assert property (p_idle_until_start) else $error("status clock ran early");
  property p_all_and;
    @(posedge clk) disable iff (reset)
      all_status_and == (&proc_status);
  endproperty
  a_all_and: assert property (p_all_and) else $error("all-status not AND of status");
  property p_data_mid;
    @(posedge clk) disable iff (reset)
      !$stable(debug_data) |-> !status_clock ##1 (status_clock || status_clock_disable_bit);
  endproperty
  a_data_mid: assert property (p_data_mid) else $error("status clock not centred");

  // checks, test clock domain
  property p_tdo_oe;
    @(posedge tclk) disable iff (!trst_n)
      tdo_oe |-> tap_state == djtp_pkg::TAP_SH_IR || tap_state == djtp_pkg::TAP_SH_DR;
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("tdo driven outside shift");
  property p_tap_step;
    @(posedge tclk) disable iff (!trst_n)
      jm_s2 && tap_state == djtp_pkg::TAP_RESET && !tms |=> tap_state == djtp_pkg::TAP_IDLE;
  endproperty
  a_tap_step: assert property (p_tap_step) else $error("tap did not leave reset");
  property p_tdo_edge;
    @(negedge tclk) disable iff (!trst_n)
      tdo == tdo_rise_reg;
  endproperty
  a_tdo_edge: assert property (p_tdo_edge) else $error("tdo changed unexpectedly");

endmodule

// file: test/djtp_host_model.sv
// model of the external development system on the debug pins
`timescale 1ns/100ps
module djtp_host_model (
  input wire logic clk,
  output logic tclk,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic dev_serial_clock,
  output logic dev_serial_in,
  input wire logic dev_serial_out
);
  logic last_tdo;
  logic tdo_wire;
  initial begin
    tclk = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    dev_serial_clock = 1'b0;
    dev_serial_in = 1'b0;
    last_tdo = 1'b0;
  end
  // released pin shows the inverse of its last driven level
  always @(tdo or tdo_oe) begin
    if (tdo_oe) begin
      last_tdo = tdo;
    end
  end
  assign tdo_wire = tdo_oe ? tdo : ~last_tdo;
  // one 48 ns test clock period, clock stands low between calls
  task tck(input logic tms_v, input logic tdi_v, output logic pre, output logic post);
    tms = tms_v;
    tdi = tdi_v;
    #24;
    pre = tdo_wire;
    tclk = 1'b1;
    #1;
    post = tdo_wire;
    #22;
    tclk = 1'b0;
    #1;
  endtask
  // one serial bit, period of ten bus clocks or more
  task ser_bit(input logic din, output logic dout);
    @(posedge clk);
    dev_serial_in <= din;
    dev_serial_clock <= 1'b1;
    repeat (5) @(posedge clk);
    dev_serial_clock <= 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    dout = dev_serial_out;
  endtask
  task ser_packet(input logic [16:0] din, output logic [16:0] dout);
    for (int i = 16; i >= 0; i--) begin
      ser_bit(din[i], dout[i]);
    end
  endtask
  // one-cycle spike on the serial clock
  task ser_glitch;
    @(posedge clk);
    dev_serial_clock <= 1'b1;
    @(posedge clk);
    dev_serial_clock <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench of the debug port
`timescale 1ns/100ps
module tb_top;
  logic clk, reset, jtag_select, trst_n;
  logic breakpoint_request, instr_done, resume;
  djtp_pkg::djtp_trace_t core_trace;
  wire logic tclk, tms, tdi, tdo, tdo_oe, dev_serial_clock, dev_serial_in, dev_serial_out;
  wire logic halt_request, debug_irq, jtag_mode, status_clock, all_status_and;
  wire logic [3:0] proc_status, debug_data;
  int fails, num_checks;
  logic [16:0] r;
  logic [31:0] v;

  djtp_top uut (.clk(clk), .reset(reset), .jtag_select(jtag_select), .trst_n(trst_n),
    .tclk(tclk), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .dev_serial_clock(dev_serial_clock), .dev_serial_in(dev_serial_in), .dev_serial_out(dev_serial_out),
    .breakpoint_request(breakpoint_request), .core_trace(core_trace), .instr_done(instr_done),
    .resume(resume), .halt_request(halt_request), .debug_irq(debug_irq), .jtag_mode(jtag_mode),
    .proc_status(proc_status), .debug_data(debug_data), .status_clock(status_clock),
    .all_status_and(all_status_and));

  djtp_host_model host (.clk(clk), .tclk(tclk), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .dev_serial_clock(dev_serial_clock), .dev_serial_in(dev_serial_in), .dev_serial_out(dev_serial_out));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task do_reset(input logic sel);
    @(posedge clk);
    jtag_select <= sel;
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(jtag_mode, sel);
  endtask

  // waits for a falling status clock, bounded
  task wait_fall;
    logic p;
    p = status_clock;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (p === 1'b1 && status_clock === 1'b0) return;
      p = status_clock;
    end
    fails++;
    $display("unexpected at %0t: status clock stuck", $time);
    give_verdict;
  endtask

  task go(input logic [7:0] seq, input int n);
    logic a, b;
    for (int i = 0; i < n; i++) host.tck(seq[i], 1'b0, a, b);
  endtask

  task shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic a, b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      check(tdo_oe, 1'b1);
      host.tck(i == n - 1, din[i], b, a);
      check(a, b);
      dout[i] = b;
    end
    check(tdo_oe, 1'b0);
  endtask

  task test_trace;
    repeat (8) begin
      @(negedge clk);
      check(status_clock, 1'b0);
    end
    @(posedge clk);
    core_trace <= {4'hC, 4'h5};
    wait_fall;
    wait_fall;
    check(proc_status, 4'hC);
    check(debug_data, 4'h5);
    check(all_status_and, 1'b0);
    @(negedge clk);
    check({status_clock, proc_status}, 5'h1C);
    @(posedge clk);
    core_trace <= {4'hF, 4'hA};
    wait_fall;
    wait_fall;
    check(all_status_and, 1'b1);
    check(debug_data, 4'hA);
    $display("trace test done");
  endtask

  task test_serial;
    logic [8:0] snap;
    int n;
    host.ser_glitch;
    host.ser_packet({1'b0, djtp_pkg::CMD_WRITE_CFG, 8'h03}, r);
    check(r, 17'h0);
    host.ser_packet(17'h0, r);
    check(r, 17'h00000);
    @(posedge clk);
    core_trace <= {4'hD, 4'h3};
    @(negedge clk);
    snap = {status_clock, proc_status, debug_data};
    repeat (10) begin
      @(negedge clk);
      check({status_clock, proc_status, debug_data}, snap);
    end
    @(posedge clk);
    breakpoint_request <= 1'b1;
    instr_done <= 1'b1;
    n = 0;
    repeat (8) begin
      @(negedge clk);
      n += debug_irq;
      check(halt_request, 1'b0);
    end
    check(n, 1);
    @(posedge clk);
    breakpoint_request <= 1'b0;
    instr_done <= 1'b0;
    host.ser_packet({1'b0, djtp_pkg::CMD_WRITE_CFG, 8'h00}, r);
    check(r, 17'h00003);
    $display("serial test done");
  endtask

  task test_halt;
    @(posedge clk);
    core_trace <= {4'hC, 4'h2};
    breakpoint_request <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(halt_request, 1'b0);
    @(posedge clk);
    instr_done <= 1'b1;
    breakpoint_request <= 1'b0;
    @(posedge clk);
    instr_done <= 1'b0;
    @(negedge clk);
    check(halt_request, 1'b1);
    wait_fall;
    wait_fall;
    check(proc_status, djtp_pkg::PST_HALT);
    @(posedge clk);
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    @(negedge clk);
    check(halt_request, 1'b0);
    @(posedge clk);
    breakpoint_request <= 1'b1;
    instr_done <= 1'b1;
    repeat (3) @(posedge clk);
    breakpoint_request <= 1'b0;
    instr_done <= 1'b0;
    @(negedge clk);
    check(halt_request, 1'b1);
    @(posedge clk);
    resume <= 1'b1;
    @(posedge clk);
    resume <= 1'b0;
    @(negedge clk);
    check(halt_request, 1'b0);
    $display("halt test done");
  endtask

  task test_tap;
    do_reset(1'b1);
    check(tdo_oe, 1'b0);
    @(posedge clk);
    trst_n <= 1'b1;
    #3;
    go(8'h1F, 6);
    check(tdo_oe, 1'b0);
    go(8'h03, 4);
    shift(4, 32'hF, v);
    check(v[3:0], djtp_pkg::IR_CAPTURE);
    go(8'h01, 2);
    go(8'h01, 3);
    shift(8, 32'hA5, v);
    check(v[7:0], 8'h4A);
    go(8'h01, 2);
    go(8'h01, 3);
    check(tdo_oe, 1'b1);
    @(posedge clk);
    trst_n <= 1'b0;
    #1;
    check(tdo_oe, 1'b0);
    @(posedge clk);
    trst_n <= 1'b1;
    #3;
    go(8'h1F, 6);
    go(8'h01, 3);
    shift(32, 32'h0, v);
    check(v, djtp_pkg::ID_VALUE);
    $display("tap test done");
  endtask

  initial begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    jtag_select = 1'b0;
    trst_n = 1'b0;
    breakpoint_request = 1'b0;
    instr_done = 1'b0;
    resume = 1'b0;
    core_trace = '0;
    do_reset(1'b0);
    test_trace;
    test_serial;
    test_halt;
    test_tap;
    give_verdict;
  end

  initial begin
    #200000;
    fails++;
    $display("unexpected at %0t: run limit reached", $time);
    give_verdict;
  end
endmodule
